// ===== inc/mts_pkg.sv
// Package for the MOVX target steering block: SFR map, fields, resets, types
`default_nettype none
package mts_pkg;

  // ******************************
  // SFR offsets
  // ******************************
  localparam logic [7:0] MTS_ADDR_PTR_LO    = 8'h82;
  localparam logic [7:0] MTS_ADDR_PTR_HI    = 8'h83;
  localparam logic [7:0] MTS_ADDR_STORE_CTL = 8'h8F;
  localparam logic [7:0] MTS_ADDR_EMCF  = 8'hA3;
  localparam logic [7:0] MTS_ADDR_PAGE  = 8'hAF;

  // ******************************
  // Field positions
  // ******************************
  localparam int MTS_PS_WE_BIT  = 0;
  localparam int MTS_PS_EE_BIT  = 1;
  localparam int MTS_PS_SP_BIT  = 2;
  localparam int MTS_EM_PRT_BIT = 5;

  // ******************************
  // Reset values
  // ******************************
  localparam logic [7:0] MTS_RST_STORE_CTL = 8'h00;
  localparam logic [7:0] MTS_RST_PTR       = 8'h00;
  localparam logic [7:0] MTS_RST_PAGE  = 8'h00;
  localparam logic [7:0] MTS_RST_EMCF  = 8'h03;

  // ******************************
  // Memory geometry
  // ******************************
  localparam int MTS_EXTERNAL_DATA_RAM_AW    = 12;
  localparam int MTS_SECTOR_AW  = 9;
  localparam int MTS_SCRATCH_AW = 7;

  // ******************************
  // Types
  // ******************************
  typedef enum logic [3:0] {
    MTS_TGT_EXTERNAL_DATA_RAM  = 4'h1,
    MTS_TGT_FPROG = 4'h2,
    MTS_TGT_FERASE = 4'h4,
    MTS_TGT_FREAD = 4'h8
  } mts_tgt_t;

endpackage
`default_nettype wire

// ===== hdl/mts_top.sv
// MOVX target steering: address forming and routing to EXTERNAL_DATA_RAM or flash
//
// How it works
// RULE1 - Scratch select sends flash accesses to scratchpad
// RULE2 - Scratch clear sends flash accesses to main array
// RULE3 - Software keeps scratchpad addresses below 0x80
// RULE4 - Erase plus write enables make writes erase
// RULE5 - Erase ignores the supplied data byte
// RULE6 - Write enable alone programs the byte
// RULE7 - Software erases a location before programming
// RULE8 - MOVX reaches 4k bytes of on-chip RAM
// RULE9 - No flash enables means MOVX hits EXTERNAL_DATA_RAM
// RULE10 - Long form uses full data pointer
// RULE11 - Short form uses page byte and Ri
// RULE12 - Data pointer readable as two byte SFRs
// RULE13 - Memory interface on low or high ports
// RULE14 - Page erase clears whole 512-byte sector
// RULE15 - No instruction fetch from scratchpad sector
// RULE16 - Store control bits reset to zero
`timescale 1ns/100ps
`default_nettype none
module mts_top
  import mts_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       resetn,
  input  wire logic                       sfr_wr,
  input  wire logic                       sfr_rd,
  input  wire logic [7:0]                 sfr_addr,
  input  wire logic [7:0]                 sfr_wdata,
  output var  logic [7:0]                 sfr_rdata,
  output var  logic                       sfr_hit,
  input  wire logic                       movx_req,
  input  wire logic                       movx_we,
  input  wire logic                       movx_long,
  input  wire logic [7:0]                 movx_ri,
  input  wire logic [7:0]                 movx_wdata,
  input  wire logic                       code_req,
  input  wire logic                       code_is_data,
  input  wire logic [15:0]                code_addr,
  output var  logic                       external_data_ram_en,
  output var  logic                       external_data_ram_we,
  output var  logic [MTS_EXTERNAL_DATA_RAM_AW-1:0]     external_data_ram_addr,
  output var  logic [7:0]                 external_data_ram_wdata,
  output var  logic                       flash_rd,
  output var  logic                       flash_prog,
  output var  logic                       flash_erase,
  output var  logic                       flash_scratch,
  output var  logic [15:0]                flash_addr,
  output var  logic [7:0]                 flash_wdata,
  output var  logic                       ext_mem_high_ports
);
  import mts_pkg::*;

  // ******************************
  // State
  // ******************************
  typedef struct packed {
    logic                   sp;
    logic                   ee;
    logic                   we;
    logic [7:0]             ptr_hi;
    logic [7:0]             ptr_lo;
    logic [7:0]             page;
    logic [7:0]             emcf;
    logic [7:0]             rdata;
    logic                   hit;
    logic                   x_en;
    logic                   x_we;
    logic [MTS_EXTERNAL_DATA_RAM_AW-1:0] x_addr;
    logic [7:0]             x_wdata;
    logic                   f_rd;
    logic                   f_prog;
    logic                   f_erase;
    logic                   f_sp;
    logic [15:0]            f_addr;
    logic [7:0]             f_wdata;
  } mts_state_t;

  mts_state_t s_q;
  mts_state_t s_d;
  logic [15:0] eff_addr;
  mts_tgt_t    tgt;

  // ******************************
  // Decoding
  // ******************************
  function automatic mts_tgt_t mts_target(
    input logic we_bit,
    input logic ee_bit,
    input logic is_write
  );
    mts_target = MTS_TGT_EXTERNAL_DATA_RAM;
    if (is_write && we_bit && ee_bit)
    begin
      mts_target = MTS_TGT_FERASE; // [RULE4]
    end
    else if (is_write && we_bit)
    begin
      mts_target = MTS_TGT_FPROG; // [RULE6]
    end
  endfunction

  // Erase clears a whole block, so the address is aligned to it
  function automatic logic [15:0] mts_erase_base(
    input logic        scratch,
    input logic [15:0] a
  );
    if (scratch)
    begin
      mts_erase_base = {a[15:MTS_SCRATCH_AW], {MTS_SCRATCH_AW{1'b0}}};
    end
    else
    begin
      mts_erase_base = {a[15:MTS_SECTOR_AW], {MTS_SECTOR_AW{1'b0}}}; // [RULE14]
    end
  endfunction

  function automatic logic mts_known(input logic [7:0] a);
    mts_known = (a == MTS_ADDR_PTR_LO) || (a == MTS_ADDR_PTR_HI) ||
                (a == MTS_ADDR_STORE_CTL) || (a == MTS_ADDR_EMCF) ||
                (a == MTS_ADDR_PAGE);
  endfunction

  // ******************************
  // Next state
  // ******************************
  always_comb
  begin
    s_d = s_q;
    s_d.x_en = 1'b0;
    s_d.x_we = 1'b0;
    s_d.f_rd = 1'b0;
    s_d.f_prog = 1'b0;
    s_d.f_erase = 1'b0;
    s_d.hit = 1'b0;

    // Long form takes the pointer, short form page plus Ri
    if (movx_long)
    begin
      eff_addr = {s_q.ptr_hi, s_q.ptr_lo}; // [RULE10]
    end
    else
    begin
      eff_addr = {s_q.page, movx_ri}; // [RULE11]
    end

    // With no flash enables every MOVX lands in EXTERNAL_DATA_RAM
    tgt = mts_target(s_q.we, s_q.ee, movx_we); // [RULE9]

    if (movx_req)
    begin
      unique case (tgt)
        MTS_TGT_EXTERNAL_DATA_RAM:
        begin
          // On-chip only: upper bits alias onto the 4k array
          s_d.x_en = 1'b1; // [RULE8]
          s_d.x_we = movx_we;
          s_d.x_addr = eff_addr[MTS_EXTERNAL_DATA_RAM_AW-1:0];
          s_d.x_wdata = movx_wdata;
        end
        MTS_TGT_FPROG:
        begin
          // Target location must already be erased by software [RULE7]
          s_d.f_prog = 1'b1; // [RULE6]
          s_d.f_sp = s_q.sp; // [RULE1] [RULE2]
          s_d.f_addr = eff_addr;
          s_d.f_wdata = movx_wdata;
        end
        MTS_TGT_FERASE:
        begin
          s_d.f_erase = 1'b1; // [RULE4]
          s_d.f_sp = s_q.sp; // [RULE1] [RULE2]
          s_d.f_addr = mts_erase_base(s_q.sp, eff_addr); // [RULE14]
          s_d.f_wdata = 8'h00; // [RULE5]
        end
        MTS_TGT_FREAD:
        begin
          s_d.f_rd = 1'b0;
        end
      endcase
    end
    else if (code_req)
    begin
      // Fetches never see the scratchpad; only data reads do
      s_d.f_rd = 1'b1;
      s_d.f_sp = code_is_data && s_q.sp; // [RULE15] [RULE1] [RULE2]
      // Upper bits out of range give undefined results [RULE3]
      s_d.f_addr = code_addr;
    end

    // SFR writes land after any MOVX of the same cycle
    if (sfr_wr)
    begin
      unique case (sfr_addr)
        MTS_ADDR_PTR_LO:
        begin
          s_d.ptr_lo = sfr_wdata; // [RULE12]
        end
        MTS_ADDR_PTR_HI:
        begin
          s_d.ptr_hi = sfr_wdata; // [RULE12]
        end
        MTS_ADDR_STORE_CTL:
        begin
          s_d.we = sfr_wdata[MTS_PS_WE_BIT];
          s_d.ee = sfr_wdata[MTS_PS_EE_BIT];
          s_d.sp = sfr_wdata[MTS_PS_SP_BIT];
        end
        MTS_ADDR_EMCF:
        begin
          s_d.emcf = sfr_wdata; // [RULE13]
        end
        MTS_ADDR_PAGE:
        begin
          s_d.page = sfr_wdata; // [RULE11]
        end
        default:
        begin
          s_d.hit = 1'b0;
        end
      endcase
    end

    // Register read-back; unused control bits read zero
    if (sfr_rd)
    begin
      s_d.hit = mts_known(sfr_addr);
      unique case (sfr_addr)
        MTS_ADDR_PTR_LO:
        begin
          s_d.rdata = s_q.ptr_lo; // [RULE12]
        end
        MTS_ADDR_PTR_HI:
        begin
          s_d.rdata = s_q.ptr_hi; // [RULE12]
        end
        MTS_ADDR_STORE_CTL:
        begin
          s_d.rdata = 8'h00;
          s_d.rdata[MTS_PS_WE_BIT] = s_q.we;
          s_d.rdata[MTS_PS_EE_BIT] = s_q.ee;
          s_d.rdata[MTS_PS_SP_BIT] = s_q.sp;
        end
        MTS_ADDR_EMCF:
        begin
          s_d.rdata = s_q.emcf;
        end
        MTS_ADDR_PAGE:
        begin
          s_d.rdata = s_q.page;
        end
        default:
        begin
          s_d.rdata = 8'h00;
        end
      endcase
    end
  end

  // ******************************
  // Registers
  // ******************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      // Flash stays untouched until software sets the enables
      s_q.we <= MTS_RST_STORE_CTL[MTS_PS_WE_BIT]; // [RULE16]
      s_q.ee <= MTS_RST_STORE_CTL[MTS_PS_EE_BIT]; // [RULE16]
      s_q.sp <= MTS_RST_STORE_CTL[MTS_PS_SP_BIT]; // [RULE16]
      s_q.ptr_hi <= MTS_RST_PTR;
      s_q.ptr_lo <= MTS_RST_PTR;
      s_q.page <= MTS_RST_PAGE;
      s_q.emcf <= MTS_RST_EMCF;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ******************************
  // Outputs
  // ******************************
  assign sfr_rdata = s_q.rdata;
  assign sfr_hit = s_q.hit;
  assign external_data_ram_en = s_q.x_en;
  assign external_data_ram_we = s_q.x_we;
  assign external_data_ram_addr = s_q.x_addr;
  assign external_data_ram_wdata = s_q.x_wdata;
  assign flash_rd = s_q.f_rd;
  assign flash_prog = s_q.f_prog;
  assign flash_erase = s_q.f_erase;
  assign flash_scratch = s_q.f_sp;
  assign flash_addr = s_q.f_addr;
  assign flash_wdata = s_q.f_wdata;
  assign ext_mem_high_ports = s_q.emcf[MTS_EM_PRT_BIT]; // [RULE13]

endmodule // mts_top
`default_nettype wire

// ===== tb/mts_core_model.sv
// Core-side model issuing SFR accesses, MOVX requests and code reads
`timescale 1ns/100ps
`default_nettype none
module mts_core_model (
  input  wire logic        clk,
  output var  logic        sfr_wr,
  output var  logic        sfr_rd,
  output var  logic [7:0]  sfr_addr,
  output var  logic [7:0]  sfr_wdata,
  output var  logic        movx_req,
  output var  logic        movx_we,
  output var  logic        movx_long,
  output var  logic [7:0]  movx_ri,
  output var  logic [7:0]  movx_wdata,
  output var  logic        code_req,
  output var  logic        code_is_data,
  output var  logic [15:0] code_addr
);
  // ****************************
  // Bus tasks, one idle cycle each
  // ****************************
  initial {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, movx_req, movx_we, movx_long, movx_ri, movx_wdata} = '0;
  initial {code_req, code_is_data, code_addr} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1 {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    @(posedge clk) #1 sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) #1 {sfr_rd, sfr_addr} = {1'b1, a};
    @(posedge clk) #1 sfr_rd = 1'b0;
  endtask
  task automatic mx(input logic we, input logic lg, input logic [7:0] ri, input logic [7:0] d);
    @(posedge clk) #1 {movx_req, movx_we, movx_long, movx_ri, movx_wdata} = {1'b1, we, lg, ri, d};
    @(posedge clk) #1 movx_req = 1'b0;
  endtask
  task automatic cr(input logic dat, input logic [15:0] a);
    @(posedge clk) #1 {code_req, code_is_data, code_addr} = {1'b1, dat, a};
    @(posedge clk) #1 code_req = 1'b0;
  endtask
endmodule // mts_core_model
`default_nettype wire

// ===== tb/mts_monitor.sv
// Port checker for the MOVX steering block
`timescale 1ns/100ps
`default_nettype none
module mts_monitor
  import mts_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_hit,
  input  wire logic        movx_req,
  input  wire logic        movx_we,
  input  wire logic        code_req,
  input  wire logic        code_is_data,
  input  wire logic        external_data_ram_en,
  input  wire logic        external_data_ram_we,
  input  wire logic        flash_rd,
  input  wire logic        flash_prog,
  input  wire logic        flash_erase,
  input  wire logic        flash_scratch,
  input  wire logic [15:0] flash_addr,
  input  wire logic [7:0]  flash_wdata
);
  // ****************************
  // Properties
  // ****************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_rd; movx_req && !movx_we |=> external_data_ram_en && !external_data_ram_we && !flash_prog && !flash_erase; endproperty
  a_rd: assert property (p_rd) else $error("movx read missed external_data_ram");
  property p_one; movx_req && movx_we |=> $onehot({external_data_ram_en, flash_prog, flash_erase}); endproperty
  a_one: assert property (p_one) else $error("write target not unique");
  property p_idle; !movx_req |=> !external_data_ram_en && !flash_prog && !flash_erase; endproperty
  a_idle: assert property (p_idle) else $error("strobe without request");
  property p_ed; flash_erase |-> flash_wdata == 8'h00; endproperty
  a_ed: assert property (p_ed) else $error("erase carried data");
  property p_sec; flash_erase && !flash_scratch |-> flash_addr[8:0] == 9'h000; endproperty
  a_sec: assert property (p_sec) else $error("sector erase unaligned");
  property p_sp; flash_erase && flash_scratch |-> flash_addr[6:0] == 7'h00; endproperty
  a_sp: assert property (p_sp) else $error("scratch erase unaligned");
  property p_fet; code_req && !movx_req && !code_is_data |=> flash_rd && !flash_scratch; endproperty
  a_fet: assert property (p_fet) else $error("fetch reached scratchpad");
  property p_cod; code_req && !movx_req |=> flash_rd; endproperty
  a_cod: assert property (p_cod) else $error("code read lost");
  property p_hit; sfr_rd && sfr_addr == MTS_ADDR_PTR_HI |=> sfr_hit; endproperty
  a_hit: assert property (p_hit) else $error("pointer byte not mapped");
  c_er: cover property (flash_erase);
  c_pg: cover property (flash_prog);
  c_xw: cover property (external_data_ram_en && external_data_ram_we);
endmodule // mts_monitor
bind mts_top mts_monitor u_mon (.*);
`default_nettype wire

// ===== tb/movx_target_steering_test.sv
// Self-checking bench for the MOVX steering block
`timescale 1ns/100ps
`default_nettype none
module movx_target_steering_test;
  import mts_pkg::*;
  logic clk, resetn, sfr_wr, sfr_rd, movx_req, movx_we, movx_long, code_req, code_is_data;
  logic [7:0] sfr_addr, sfr_wdata, movx_ri, movx_wdata, sfr_rdata, external_data_ram_wdata, flash_wdata, d, pg, ri;
  logic [15:0] code_addr, flash_addr, dp, ea;
  logic [MTS_EXTERNAL_DATA_RAM_AW-1:0] external_data_ram_addr;
  logic sfr_hit, external_data_ram_en, external_data_ram_we, flash_rd, flash_prog, flash_erase, flash_scratch, ext_mem_high_ports, we, lg;
  logic [2:0] c;
  logic [31:0] v;
  int miscompares, num_checks;
  mts_top dut (.*);
  mts_core_model core (.*);
  // ****************************
  // Clock, checks, verdict
  // ****************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected at %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Run is about 590 cycles; generous margin
  initial
  begin
    #100000;
    miscompares++;
    results;
  end
  initial
  begin
    void'($urandom(32'hB0B55BFC));
    resetn = 1'b0;
    repeat (16) @(posedge clk);
    #1 resetn = 1'b1;
    core.rd(MTS_ADDR_STORE_CTL);
    chk(sfr_rdata, MTS_RST_STORE_CTL);
    core.rd(8'h01);
    chk(sfr_hit, 1'b0);
    core.rd(MTS_ADDR_EMCF);
    chk(ext_mem_high_ports, 1'b0);
    core.wr(MTS_ADDR_EMCF, 8'h23);
    chk(ext_mem_high_ports, 1'b1);
    $display("reset and port test done");
    for (int i = 0; i < 40; i++)
    begin
      v = $urandom;
      c = (i < 8) ? i[2:0] : v[2:0];
      {we, lg} = v[4:3];
      d = $urandom;
      dp = $urandom;
      {pg, ri} = $urandom;
      // Scratchpad accesses kept inside its 128 bytes
      if (c[2]) {dp, pg, ri} = {dp & 16'h007F, 8'h00, ri & 8'h7F};
      core.wr(MTS_ADDR_STORE_CTL, {v[15:11], c});
      core.wr(MTS_ADDR_PTR_HI, dp[15:8]);
      core.wr(MTS_ADDR_PTR_LO, dp[7:0]);
      core.wr(MTS_ADDR_PAGE, pg);
      core.rd(MTS_ADDR_STORE_CTL);
      chk(sfr_rdata, {5'h00, c});
      core.rd(MTS_ADDR_PTR_HI);
      chk(sfr_rdata, dp[15:8]);
      ea = lg ? dp : {pg, ri};
      core.mx(we, lg, ri, d);
      if (we && c[0])
      begin
        chk(flash_erase, c[1]);
        chk(flash_prog, !c[1]);
        chk(flash_scratch, c[2]);
        chk(flash_addr, c[1] ? ea & (c[2] ? 16'hFF80 : 16'hFE00) : ea);
        chk(flash_wdata, c[1] ? 8'h00 : d);
      end
      else
      begin
        chk(external_data_ram_en, 1'b1);
        chk(external_data_ram_we, we);
        chk(external_data_ram_addr, ea[MTS_EXTERNAL_DATA_RAM_AW-1:0]);
        chk(external_data_ram_wdata, d);
      end
    end
    $display("movx test done");
    core.wr(MTS_ADDR_STORE_CTL, 8'h04);
    for (int k = 0; k < 2; k++)
    begin
      v = $urandom;
      core.cr(k[0], {9'h000, v[6:0]});
      chk(flash_rd, 1'b1);
      chk(flash_scratch, k[0]);
      chk(flash_addr, {9'h000, v[6:0]});
    end
    $display("code read test done");
    results;
  end
endmodule // movx_target_steering_test
`default_nettype wire
